// *** logic/rtcc_map.svh ***
`ifndef RTCC_MAP_SVH
`define RTCC_MAP_SVH

// Byte addresses of the clock window at the top of the array
`define RTCC_ADDR_CTRL 15'h7ff8
`define RTCC_ADDR_SEC 15'h7ff9
`define RTCC_ADDR_MIN 15'h7ffa
`define RTCC_ADDR_HOUR 15'h7ffb
`define RTCC_ADDR_DAY 15'h7ffc
`define RTCC_ADDR_DATE 15'h7ffd
`define RTCC_ADDR_MONTH 15'h7ffe
`define RTCC_ADDR_YEAR 15'h7fff

// Control byte fields
`define RTCC_CTRL_WRITE_BIT 7
`define RTCC_CTRL_READ_BIT 6
`define RTCC_CTRL_SIGN_BIT 5
`define RTCC_CTRL_MAG_MSB 4

// Seconds and day byte fields
`define RTCC_SEC_HALT_BIT 7
`define RTCC_DAY_TEST_BIT 6
`define RTCC_DAY_CENT_EN_BIT 5
`define RTCC_DAY_CENT_BIT 4

// Packed decimal limits
`define RTCC_SEC_LAST 8'h59
`define RTCC_MIN_LAST 8'h59
`define RTCC_HOUR_LAST 8'h23
`define RTCC_WDAY_FIRST 8'h01
`define RTCC_WDAY_LAST 8'h07
`define RTCC_DATE_FIRST 8'h01
`define RTCC_MONTH_FIRST 8'h01
`define RTCC_MONTH_LAST 8'h12
`define RTCC_YEAR_LAST 8'h99

// Reset values
`define RTCC_CTRL_RESET 8'h00
`define RTCC_ZERO_RESET 8'h00
`define RTCC_ONE_RESET 8'h01

// Divider chain counts: stage lengths in oscillator cycles, then stages per second, last cycle minute, test divider bit
`define RTCC_STAGE_LEN 9'd256
`define RTCC_NEG_BLANK 9'd128
`define RTCC_STAGES_PER_SEC 8'd128
`define RTCC_CAL_CYCLE_LAST 6'd63
`define RTCC_TEST_DIV_MSB 5

`endif

// *** logic/rtcc_pkg.sv ***
package rtcc_pkg;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } rtcc_time_t;

  typedef struct packed {
    logic write_hold;
    logic read_hold;
    logic cal_sign;
    logic [4:0] cal_mag;
  } rtcc_ctrl_t;

  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [14:0] addr;
    logic [7:0] wdata;
  } rtcc_bus_req_t;

endpackage

// *** logic/rtcc_top.sv ***
`timescale 1ns/1ns
`include "rtcc_map.svh"
// Overview of operation
// RQ1 - Calibrate by altering divide-by-256 stage counts
// RQ2 - Magnitude is five bits, values 0 to 31
// RQ3 - Sign bit one speeds up, zero slows
// RQ4 - 64-minute cycle, 62 eligible, one second each
// RQ5 - Adjust 256 cycles positive, 128 negative
// RQ6 - Magnitude N adjusts first 2N minutes only
// RQ7 - Net +512 or -256 cycles per step
// RQ8 - Test bit toggles bit zero at 512 Hz
// RQ9 - Test output taken ahead of calibration
// RQ10 - Test bit cleared at power-up
// RQ11 - Host clears test bit after testing
// RQ12 - Control: write, read, sign, magnitude
// RQ13 - Host writes zero to fixed-zero bits
// RQ14 - Century flag toggles at rollover when enabled
// RQ15 - Century bits writable without write bit
// RQ16 - Day byte: enable, flag, weekday 01-07
// RQ17 - Hour packed decimal 00-23, top bits zero
// RQ18 - Year packed decimal 00-99, tens high
// RQ19 - Write bit freezes; clearing loads counters
// RQ20 - Halt bit stops oscillator; restarts on clear
// RQ21 - Seconds, minutes, date, month ranges roll over
// RQ22 - Read bit freezes user-visible snapshot
module rtcc_top
  import rtcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic osc_tick,
  input wire rtcc_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid
);

  ////////////////////////////////////////////////////////////////////////////
  // Packed decimal helpers

  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    logic [8:0] r;
    r = {1'b0, v};
    if (v >= last) begin
      r = {1'b1, first};
    end else if (v[3:0] >= 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  function automatic logic leap_year(input logic [7:0] y);
    logic r;
    r = 1'b0;
    if (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) begin
      r = 1'b1;
    end else if (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6)) begin
      r = 1'b1;
    end
    return r;
  endfunction

  function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
    logic [7:0] r;
    r = 8'h31;
    case (m)
      8'h02: r = leap_year(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  rtcc_ctrl_t ctrl;
  rtcc_time_t cnt;
  rtcc_time_t usr;
  logic osc_halt;
  logic freq_test_enable;
  logic century_toggle_enable;
  logic century_flag;
  logic [8:0] stage_cnt;
  logic [7:0] stage_idx;
  logic [5:0] cal_min;
  logic [5:0] test_div;
  logic data_line_zero;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic bus_wr;
  logic bus_rd;
  logic wr_ctrl;
  logic wr_sec;
  logic wr_day;
  logic wr_time;
  logic load_pulse;

  assign bus_wr = clk_en && bus_req.sel && bus_req.wr;
  assign bus_rd = clk_en && bus_req.sel && bus_req.rd && !bus_req.wr;
  assign wr_ctrl = bus_wr && bus_req.addr == `RTCC_ADDR_CTRL;
  assign wr_sec = bus_wr && bus_req.addr == `RTCC_ADDR_SEC;
  assign wr_day = bus_wr && bus_req.addr == `RTCC_ADDR_DAY;
  // Time fields take host data only while updates are frozen for setting
  assign wr_time = bus_wr && ctrl.write_hold;
  // Falling edge of the write bit hands the set time to the counters
  assign load_pulse = wr_ctrl && ctrl.write_hold && !bus_req.wdata[`RTCC_CTRL_WRITE_BIT]; // RQ19

  ////////////////////////////////////////////////////////////////////////////
  // Divider chain with calibration

  logic osc_run;
  logic adjust_sec;
  logic adj_pos;
  logic adj_neg;
  logic [8:0] stage_len;
  logic stage_end;
  logic [7:0] stage_inc;
  logic [7:0] stage_sum;
  logic sec_tick;
  logic [6:0] cal_limit;

  assign osc_run = clk_en && osc_tick && !osc_halt; // RQ20
  assign cal_limit = {1'b0, ctrl.cal_mag, 1'b0}; // RQ6
  // Only the first second of an eligible minute is touched; 2N never passes 62
  assign adjust_sec = cnt.sec == `RTCC_ZERO_RESET && {1'b0, cal_min} < cal_limit; // RQ4
  assign adj_pos = adjust_sec && ctrl.cal_sign && stage_idx == 8'd0; // RQ3
  assign adj_neg = adjust_sec && !ctrl.cal_sign && stage_idx == 8'd0; // RQ3
  // Negative: blank 128 pulses, stretching one 256 stage to 384
  assign stage_len = adj_neg ? `RTCC_STAGE_LEN + `RTCC_NEG_BLANK : `RTCC_STAGE_LEN; // RQ5
  assign stage_end = stage_cnt == stage_len - 9'd1;
  // Positive: split a pulse so one stage counts twice, 256 cycles early
  assign stage_inc = adj_pos ? 8'd2 : 8'd1; // RQ5
  assign stage_sum = stage_idx + stage_inc;
  assign sec_tick = osc_run && stage_end && stage_sum >= `RTCC_STAGES_PER_SEC; // RQ7

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage_cnt <= 9'd0;
      stage_idx <= 8'd0;
    end else if (load_pulse) begin
      stage_cnt <= 9'd0;
      stage_idx <= 8'd0;
    end else if (osc_run) begin
      if (stage_end) begin
        stage_cnt <= 9'd0;
        stage_idx <= sec_tick ? 8'd0 : stage_sum; // RQ1
      end else begin
        stage_cnt <= stage_cnt + 9'd1;
      end
    end
  end

  // Position within the 64-minute correction cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cal_min <= 6'd0;
    end else if (sec_tick && cnt.sec == `RTCC_SEC_LAST) begin
      cal_min <= cal_min == `RTCC_CAL_CYCLE_LAST ? 6'd0 : cal_min + 6'd1; // RQ4
    end
  end

  // Test divider sits on raw oscillator pulses, so calibration cannot move it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      test_div <= 6'd0;
    end else if (osc_run) begin
      test_div <= test_div + 6'd1; // RQ9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Running counters

  rtcc_time_t next_cnt;
  logic century_roll;

  always_comb begin
    logic [8:0] s;
    logic [8:0] mi;
    logic [8:0] h;
    logic [8:0] wd;
    logic [8:0] d;
    logic [8:0] mo;
    logic [8:0] y;
    s = bcd_step(cnt.sec, `RTCC_SEC_LAST, `RTCC_ZERO_RESET); // RQ21
    mi = bcd_step(cnt.min, `RTCC_MIN_LAST, `RTCC_ZERO_RESET); // RQ21
    h = bcd_step(cnt.hour, `RTCC_HOUR_LAST, `RTCC_ZERO_RESET); // RQ17
    wd = bcd_step(cnt.wday, `RTCC_WDAY_LAST, `RTCC_WDAY_FIRST); // RQ16
    d = bcd_step(cnt.date, month_last(cnt.month, cnt.year), `RTCC_DATE_FIRST); // RQ21
    mo = bcd_step(cnt.month, `RTCC_MONTH_LAST, `RTCC_MONTH_FIRST); // RQ21
    y = bcd_step(cnt.year, `RTCC_YEAR_LAST, `RTCC_ZERO_RESET); // RQ18
    next_cnt = cnt;
    century_roll = 1'b0;
    next_cnt.sec = s[7:0];
    if (s[8]) begin
      next_cnt.min = mi[7:0];
      if (mi[8]) begin
        next_cnt.hour = h[7:0];
        if (h[8]) begin
          next_cnt.wday = wd[7:0];
          next_cnt.date = d[7:0];
          if (d[8]) begin
            next_cnt.month = mo[7:0];
            if (mo[8]) begin
              next_cnt.year = y[7:0];
              century_roll = y[8];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt <= '{sec: `RTCC_ZERO_RESET, min: `RTCC_ZERO_RESET, hour: `RTCC_ZERO_RESET,
               wday: `RTCC_ONE_RESET, date: `RTCC_ONE_RESET, month: `RTCC_ONE_RESET,
               year: `RTCC_ZERO_RESET};
    end else if (load_pulse) begin
      cnt <= usr; // RQ19
    end else if (sec_tick) begin
      cnt <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User-visible registers

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      usr <= '{sec: `RTCC_ZERO_RESET, min: `RTCC_ZERO_RESET, hour: `RTCC_ZERO_RESET,
               wday: `RTCC_ONE_RESET, date: `RTCC_ONE_RESET, month: `RTCC_ONE_RESET,
               year: `RTCC_ZERO_RESET};
    end else if (wr_time) begin
      // Fixed-zero positions are not stored, so they always read back zero
      if (bus_req.addr == `RTCC_ADDR_SEC) begin
        usr.sec <= {1'b0, bus_req.wdata[6:0]}; // RQ21
      end else if (bus_req.addr == `RTCC_ADDR_MIN) begin
        usr.min <= {1'b0, bus_req.wdata[6:0]}; // RQ21
      end else if (bus_req.addr == `RTCC_ADDR_HOUR) begin
        usr.hour <= {2'b00, bus_req.wdata[5:0]}; // RQ17
      end else if (bus_req.addr == `RTCC_ADDR_DAY) begin
        usr.wday <= {5'b00000, bus_req.wdata[2:0]}; // RQ16
      end else if (bus_req.addr == `RTCC_ADDR_DATE) begin
        usr.date <= {2'b00, bus_req.wdata[5:0]}; // RQ21
      end else if (bus_req.addr == `RTCC_ADDR_MONTH) begin
        usr.month <= {3'b000, bus_req.wdata[4:0]}; // RQ21
      end else if (bus_req.addr == `RTCC_ADDR_YEAR) begin
        usr.year <= bus_req.wdata; // RQ18
      end
    end else if (clk_en && !ctrl.write_hold && !ctrl.read_hold) begin
      usr <= cnt; // RQ22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, halt, test and century bits

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl <= `RTCC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl.write_hold <= bus_req.wdata[`RTCC_CTRL_WRITE_BIT]; // RQ12
      ctrl.read_hold <= bus_req.wdata[`RTCC_CTRL_READ_BIT]; // RQ12
      ctrl.cal_sign <= bus_req.wdata[`RTCC_CTRL_SIGN_BIT]; // RQ3
      ctrl.cal_mag <= bus_req.wdata[`RTCC_CTRL_MAG_MSB:0]; // RQ2
    end
  end

  // Halt is honoured at once so the host can stop the clock without setting up
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      osc_halt <= 1'b0;
    end else if (wr_sec) begin
      osc_halt <= bus_req.wdata[`RTCC_SEC_HALT_BIT]; // RQ20
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      freq_test_enable <= 1'b0; // RQ10
      century_toggle_enable <= 1'b0;
    end else if (wr_day) begin
      freq_test_enable <= bus_req.wdata[`RTCC_DAY_TEST_BIT];
      century_toggle_enable <= bus_req.wdata[`RTCC_DAY_CENT_EN_BIT]; // RQ15
    end
  end

  // A rollover in the cycle of a host write still toggles the written value
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      century_flag <= 1'b0;
    end else if (clk_en) begin
      century_flag <= (wr_day ? bus_req.wdata[`RTCC_DAY_CENT_BIT] : century_flag) ^ // RQ15
        (sec_tick && !load_pulse && century_roll && century_toggle_enable); // RQ14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [7:0] read_byte;

  assign data_line_zero = freq_test_enable && !osc_halt ? test_div[`RTCC_TEST_DIV_MSB] :
                          usr.sec[0]; // RQ8

  always_comb begin
    read_byte = 8'h00;
    if (bus_req.addr == `RTCC_ADDR_CTRL) begin
      read_byte = ctrl;
    end else if (bus_req.addr == `RTCC_ADDR_SEC) begin
      read_byte = {osc_halt, usr.sec[6:1], data_line_zero}; // RQ8
    end else if (bus_req.addr == `RTCC_ADDR_MIN) begin
      read_byte = usr.min;
    end else if (bus_req.addr == `RTCC_ADDR_HOUR) begin
      read_byte = usr.hour;
    end else if (bus_req.addr == `RTCC_ADDR_DAY) begin
      read_byte = {1'b0, freq_test_enable, century_toggle_enable, century_flag, 1'b0,
                   usr.wday[2:0]}; // RQ16
    end else if (bus_req.addr == `RTCC_ADDR_DATE) begin
      read_byte = usr.date;
    end else if (bus_req.addr == `RTCC_ADDR_MONTH) begin
      read_byte = usr.month;
    end else if (bus_req.addr == `RTCC_ADDR_YEAR) begin
      read_byte = usr.year;
    end
  end

  // Held read keeps resampling, so the test square wave shows on bit 0
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
      bus_rvalid <= 1'b0;
    end else if (clk_en) begin
      bus_rvalid <= bus_rd;
      if (bus_rd) begin
        bus_rdata <= read_byte;
      end
    end
  end

endmodule

// *** testbench/rtcc_props.sv ***
`timescale 1ns/1ns
`include "rtcc_map.svh"
module rtcc_props
  import rtcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic osc_tick,
  input wire rtcc_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic rd_go;
  logic wr_go;
  assign rd_go = clk_en & bus_req.sel & bus_req.rd & !bus_req.wr;
  assign wr_go = clk_en & bus_req.sel & bus_req.wr;
  function automatic logic bcd(input logic [7:0] v);
    return v[7:4] <= 4'h9 && v[3:0] <= 4'h9;
  endfunction
  // Judges the answer to a read of one clock byte
  property byte_ok(a, ok);
    bus_rvalid && $past(bus_req.addr) == a |-> ok;
  endproperty
  ////////////////////////////////////////
  chk_read_answer: assert property (rd_go |=> bus_rvalid)
    else $error("read not answered");
  chk_no_stray: assert property (!rd_go |=> !bus_rvalid)
    else $error("answer without read");
  chk_quiet_reset: assert property ($rose(rst_n) |-> !bus_rvalid && bus_rdata == 8'h00)
    else $error("bus not quiet after reset");
  chk_hour_range: assert property (
    byte_ok(`RTCC_ADDR_HOUR, bcd(bus_rdata) && bus_rdata <= 8'h23))
    else $error("hour out of range");
  chk_year_bcd: assert property (byte_ok(`RTCC_ADDR_YEAR, bcd(bus_rdata)))
    else $error("year not decimal");
  chk_day_fields: assert property (
    byte_ok(`RTCC_ADDR_DAY, !bus_rdata[7] && !bus_rdata[3] && bus_rdata[2:0] != 3'h0))
    else $error("day byte malformed");
  chk_minute_range: assert property (
    byte_ok(`RTCC_ADDR_MIN, bcd(bus_rdata) && bus_rdata <= 8'h59))
    else $error("minute out of range");
  chk_month_range: assert property (
    byte_ok(`RTCC_ADDR_MONTH, bcd(bus_rdata) && bus_rdata != 8'h00 && bus_rdata <= 8'h12))
    else $error("month out of range");
  chk_unmapped_zero: assert property (
    bus_rvalid && $past(bus_req.addr) < `RTCC_ADDR_CTRL |-> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Host leaves two idle cycles between a write and the following read
  chk_ctrl_echo: assert property (
    wr_go && bus_req.addr == `RTCC_ADDR_CTRL ##1 !wr_go [*2] ##1
    rd_go && bus_req.addr == `RTCC_ADDR_CTRL |=> bus_rdata == $past(bus_req.wdata, 4))
    else $error("control byte not kept");
  cover property (wr_go && bus_req.addr == `RTCC_ADDR_CTRL && bus_req.wdata[7]);
  cover property (rd_go && bus_req.addr == `RTCC_ADDR_SEC);
  cover property (wr_go && bus_req.addr == `RTCC_ADDR_DAY);
  cover property (wr_go && bus_req.addr == `RTCC_ADDR_CTRL && !bus_req.wdata[5] &&
    bus_req.wdata[4:0] != 5'h00);
endmodule
bind rtcc_top rtcc_props chk (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
  .osc_tick(osc_tick), .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));

// *** testbench/rtcc_host.sv ***
`timescale 1ns/1ns
module rtcc_host
  import rtcc_pkg::*;
(
  input wire logic sys_clk,
  output rtcc_bus_req_t bus_req
);
  initial bus_req = '0;
  // One access per call; callers keep fixed-zero bits clear and drop the test bit
  task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    bus_req <= '{sel: 1'b1, rd: !w, wr: w, addr: a, wdata: d};
    @(negedge sys_clk);
    // Released lines carry inverted leftovers so stale values cannot pass
    bus_req <= '{sel: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// *** testbench/rtcc_top_tb_top.sv ***
`timescale 1ns/1ns
module rtcc_top_tb_top;
  import rtcc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic osc_tick = 1'b0;
  rtcc_bus_req_t bus_req;
  logic [7:0] bus_rdata;
  logic bus_rvalid;
  logic [15:0] exp_q[$];
  logic [15:0] note;
  logic [7:0] last_rd;
  logic [15:0] lfsr = 16'h1f4c;
  logic b;
  logic [7:0] tset [1:7] = '{8'h59, 8'h59, 8'h23, 8'h27, 8'h31, 8'h12, 8'h99};
  logic [7:0] tnew [1:7] = '{8'h00, 8'h00, 8'h00, 8'h31, 8'h01, 8'h01, 8'h00};
  int n_errors = 0;
  int cmp_count = 0;
  int i;
  rtcc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .osc_tick(osc_tick),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));
  rtcc_host host (.sys_clk(sys_clk), .bus_req(bus_req));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [14:0] ra(input int o);
    return {12'hfff, 3'(o)};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    exp_q.push_back({m, e});
    host.xfer(1'b0, a, 8'h00);
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
    @(negedge sys_clk);
  endtask
  task automatic ticks(input int n);
    osc_tick <= 1'b1;
    repeat (n) @(negedge sys_clk);
    osc_tick <= 1'b0;
  endtask
  task automatic test_done();
    // A read that never answered leaves its note behind
    if (exp_q.size() != 0) n_errors++;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // An answer with no note compares against unknown and is reported
  always @(negedge sys_clk) begin
    if (bus_rvalid === 1'b1) begin
      last_rd = bus_rdata;
      note = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hffxx;
      check(bus_rdata & note[15:8], note[7:0] & note[15:8]);
    end
  end
  initial begin
    repeat (99500) @(posedge sys_clk);
    n_errors++;
    test_done();
  end
  ////////////////////////////////////////
  initial begin
    repeat (12) @(negedge sys_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(ra(i), (i > 3 && i < 7) ? 8'h01 : 8'h00);
    end
    lfsr = step(lfsr);
    rd({1'b0, lfsr[13:0]}, 8'h00);
    clk_en <= 1'b0;
    wr(ra(0), 8'h1f);
    clk_en <= 1'b1;
    rd(ra(0), 8'h00);
    wr(ra(2), {5'h06, lfsr[2:0]});
    rd(ra(2), 8'h00);
    wr(ra(4), 8'h37);
    rd(ra(4), 8'h31);
    wr(ra(1), 8'h80);
    wr(ra(4), 8'h71);
    for (i = 0; i < 2; i++) begin
      ticks(32);
      rd(ra(1), 8'h80);
    end
    wr(ra(1), 8'h00);
    rd(ra(1), 8'h00, 8'hfe);
    for (i = 0; i < 2; i++) begin
      b = last_rd[0];
      ticks(32);
      rd(ra(1), 8'h00, 8'hfe);
      check({7'h0, last_rd[0]}, {7'h0, ~b});
      lfsr = step(lfsr);
      wr(ra(0), {3'b001, lfsr[4:0]});
      rd(ra(0), {3'b001, lfsr[4:0]});
    end
    wr(ra(4), 8'h31);
    rd(ra(4), 8'h31);
    // Load 23:59:59 on the last day of a century, positive trim of one step
    wr(ra(0), 8'ha1);
    for (i = 1; i < 8; i++) wr(ra(i), tset[i]);
    wr(ra(0), 8'h21);
    ticks(32784);
    for (i = 1; i < 8; i++) rd(ra(i), tnew[i]);
    // Second 00 of cycle minute 1 is trimmed to 32512 ticks
    ticks(32480);
    rd(ra(1), 8'h00);
    wr(ra(0), 8'h61);
    ticks(32);
    rd(ra(1), 8'h00);
    wr(ra(0), 8'h21);
    rd(ra(1), 8'h01);
    // Reload at second 00 with negative trim: second 00 of cycle minute 1 stretches to 32896 ticks
    wr(ra(0), 8'h80);
    wr(ra(1), 8'h00);
    wr(ra(0), 8'h01);
    ticks(32880);
    rd(ra(1), 8'h00);
    ticks(32);
    rd(ra(1), 8'h01);
    test_done();
  end
endmodule
